// ---- hdl/ffls_pkg.sv ----
// constants and state encoding for the fieldbus fault and led status block
// assumes a single 100 MHz board clock
package ffls_pkg;

    localparam int unsigned CLK_HZ          = 100_000_000;
    localparam int unsigned FLASH_PERIOD_MS = 1000;
    localparam int unsigned HB_TIMEOUT_MS   = 100;
    localparam int unsigned FLASH_PERIOD_CYC =
        FLASH_PERIOD_MS * (CLK_HZ / 1000);
    localparam int unsigned HB_TIMEOUT_CYC =
        HB_TIMEOUT_MS * (CLK_HZ / 1000);

    localparam logic [3:0] PROFILE_ALARM = 4'h4;
    localparam logic [3:0] PROFILE_FAULT = 4'h5;
    localparam logic [2:0] ID_COUNT_MIN  = 3'h1;
    localparam logic [2:0] ID_COUNT_MAX  = 3'h4;
    localparam logic [7:0] HB_STEP       = 8'h01;

    localparam logic       RST_ALARM     = 1'b0;
    localparam logic       RST_FAULT     = 1'b0;
    localparam logic       RST_LED       = 1'b0;

    // gray along selftest -> wait -> run -> online
    typedef enum logic [2:0]
    {
        ST_SELFTEST = 3'h0,
        ST_PWAIT    = 3'h1,
        ST_PRUN     = 3'h3,
        ST_ONLINE   = 3'h2,
        ST_CSFAIL   = 3'h6,
        ST_RAMFAIL  = 3'h7
    } ffls_state_e;

endpackage

// ---- hdl/ffls_status.sv ----
// fault reaction to bus link loss and the three diagnostic leds
// assumes all inputs synchronous to clock; pulses last one cycle
`timescale 1ns/1ns
`default_nettype none

module ffls_status
#(
    parameter int unsigned FLASH_CYCLES = ffls_pkg::FLASH_PERIOD_CYC,
    parameter int unsigned HB_CYCLES    = ffls_pkg::HB_TIMEOUT_CYC,
    parameter int unsigned TO_W         = 8
)
(
    input  wire logic            clock,
    input  wire logic            rst,
    input  wire logic [TO_W-1:0] linkTimeoutSetting,
    input  wire logic [3:0]      linkProfileSelect,
    input  wire logic            ctrlWordOn,
    input  wire logic            respMonActive,
    input  wire logic            techBoardFitted,
    input  wire logic            techAlarmCfg,
    input  wire logic            techFaultCfg,
    input  wire logic            faultAck,
    input  wire logic            selfTestDone,
    input  wire logic            checksumFail,
    input  wire logic            ramFail,
    input  wire logic            boardCancelParam,
    input  wire logic            paramStart,
    input  wire logic            paramDone,
    input  wire logic            hbStrobe,
    input  wire logic [7:0]      hbValue,
    input  wire logic            syncMode,
    input  wire logic            cfgStrobe,
    input  wire logic [2:0]      cfgIdCount,
    input  wire logic            cfgProfileValid,
    input  wire logic            netDataActive,
    input  wire logic            busError,
    output logic                 busLossAlarm,
    output logic                 busLossFault,
    output logic                 badParam,
    output logic                 linkConnected,
    output logic                 telOkLed,
    output logic                 boardOkLed,
    output logic                 ifOkLed
);

    ffls_pkg::ffls_state_e state_q;
    ffls_pkg::ffls_state_e state_d;
    logic [31:0]           flashCnt_q;
    logic [31:0]           hbCnt_q;
    logic [7:0]            hbPrev_q;
    logic                  hbSeen_q;
    logic                  hbErr;
    logic                  configured_q;
    logic                  exchanging_q;
    logic                  everExchanged_q;
    logic                  lossState_q;
    logic                  timeoutZero;
    logic                  prof4;
    logic                  prof5;
    logic                  lossAny;
    logic                  cfgBad;
    logic                  alarmD;
    logic                  faultSet;
    logic                  lit;
    logic                  syncLit;

    function automatic logic cfg_invalid(input logic [2:0] cnt,
                                         input logic       profOk);
        cfg_invalid = (cnt < ffls_pkg::ID_COUNT_MIN) ||
                      (cnt > ffls_pkg::ID_COUNT_MAX) || !profOk;
    endfunction

    assign timeoutZero = (linkTimeoutSetting == '0);
    assign prof4       = (linkProfileSelect == ffls_pkg::PROFILE_ALARM);
    assign prof5       = (linkProfileSelect == ffls_pkg::PROFILE_FAULT);
    assign lossAny     = !everExchanged_q || lossState_q;
    assign cfgBad      = cfg_invalid(cfgIdCount, cfgProfileValid);
    assign lit         = (flashCnt_q < (FLASH_CYCLES / 2));
    assign syncLit     = (flashCnt_q < (FLASH_CYCLES / 4));

    // board states
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ffls_pkg::ST_SELFTEST:
            begin
                if (checksumFail)
                    state_d = ffls_pkg::ST_CSFAIL;
                else if (ramFail)
                    state_d = ffls_pkg::ST_RAMFAIL;
                else if (selfTestDone)
                    state_d = ffls_pkg::ST_PWAIT;
            end
            ffls_pkg::ST_PWAIT:
            begin
                if (paramStart)
                    state_d = ffls_pkg::ST_PRUN;
            end
            ffls_pkg::ST_PRUN:
            begin
                if (paramDone)
                    state_d = ffls_pkg::ST_ONLINE;
            end
            ffls_pkg::ST_ONLINE:
            begin
                if (boardCancelParam || hbErr)
                    state_d = ffls_pkg::ST_PWAIT;
            end
            // test failures are final until reset
            ffls_pkg::ST_CSFAIL:  state_d = ffls_pkg::ST_CSFAIL;
            ffls_pkg::ST_RAMFAIL: state_d = ffls_pkg::ST_RAMFAIL;
            default:              state_d = ffls_pkg::ST_SELFTEST;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            state_q <= ffls_pkg::ST_SELFTEST;
        else
            state_q <= state_d;
    end

    // common flash base, one period for every led
    always_ff @(posedge clock)
    begin
        if (rst || flashCnt_q >= FLASH_CYCLES - 1)
            flashCnt_q <= '0;
        else
            flashCnt_q <= flashCnt_q + 32'h00000001;
    end

    // heartbeat watch, only meaningful once online
    assign hbErr = (state_q == ffls_pkg::ST_ONLINE) &&
                   ((hbStrobe && hbSeen_q &&
                     hbValue != hbPrev_q + ffls_pkg::HB_STEP) ||
                    hbCnt_q >= HB_CYCLES);

    always_ff @(posedge clock)
    begin
        if (rst || state_q != ffls_pkg::ST_ONLINE)
        begin
            hbSeen_q <= 1'b0;
            hbPrev_q <= 8'h00;
            hbCnt_q  <= '0;
        end
        else if (hbStrobe)
        begin
            hbSeen_q <= 1'b1;
            hbPrev_q <= hbValue;
            hbCnt_q  <= '0;
        end
        else if (hbCnt_q < HB_CYCLES)
            hbCnt_q <= hbCnt_q + 32'h00000001;
    end

    // configuration telegram and link tracking
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            configured_q <= 1'b0;
            badParam     <= 1'b0;
        end
        else if (cfgStrobe)
        begin
            configured_q <= !cfgBad;
            badParam     <= cfgBad;
        end
        else if (busError)
            configured_q <= 1'b0;
    end

    // a node without net data counts as no exchange
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            exchanging_q    <= 1'b0;
            everExchanged_q <= 1'b0;
            lossState_q     <= 1'b0;
        end
        else
        begin
            exchanging_q <= configured_q && netDataActive && !busError;
            if (exchanging_q)
                everExchanged_q <= 1'b1;
            if (busError && everExchanged_q)
                lossState_q <= 1'b1;
            else if (exchanging_q)
                lossState_q <= 1'b0;
        end
    end

    // loss reaction of the converter
    always_comb
    begin
        alarmD   = 1'b0;
        faultSet = 1'b0;
        if (!timeoutZero)
        begin
            if (techBoardFitted)
            begin
                alarmD   = lossAny && techAlarmCfg;
                faultSet = lossAny && techFaultCfg;
            end
            else
            begin
                alarmD = (!everExchanged_q && (prof4 || prof5)) ||
                         (lossState_q && respMonActive && prof4);
                faultSet = lossState_q && respMonActive &&
                           prof5 && ctrlWordOn;
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            busLossAlarm <= ffls_pkg::RST_ALARM;
        else
            busLossAlarm <= alarmD;
    end

    // fault holds until acknowledged; a new cause beats the ack
    always_ff @(posedge clock)
    begin
        if (rst)
            busLossFault <= ffls_pkg::RST_FAULT;
        else if (faultSet)
            busLossFault <= 1'b1;
        else if (faultAck)
            busLossFault <= 1'b0;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            linkConnected <= 1'b0;
        else
            linkConnected <= exchanging_q;
    end

    // led patterns; one led flashes in parameterizing or fault states, the others steady, and telegram led steady dark when online without exchange
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            telOkLed   <= ffls_pkg::RST_LED;
            boardOkLed <= ffls_pkg::RST_LED;
            ifOkLed    <= ffls_pkg::RST_LED;
        end
        else
        begin
            case (state_q)
                ffls_pkg::ST_CSFAIL:
                begin
                    telOkLed   <= 1'b0;
                    boardOkLed <= lit;
                    ifOkLed    <= 1'b1;
                end
                ffls_pkg::ST_RAMFAIL:
                begin
                    telOkLed   <= 1'b1;
                    boardOkLed <= lit;
                    ifOkLed    <= 1'b1;
                end
                ffls_pkg::ST_PRUN:
                begin
                    telOkLed   <= lit;
                    boardOkLed <= 1'b1;
                    ifOkLed    <= 1'b0;
                end
                ffls_pkg::ST_ONLINE:
                begin
                    // dark telegram led without exchange
                    telOkLed   <= exchanging_q &&
                                  (syncMode ? syncLit : lit);
                    boardOkLed <= lit;
                    ifOkLed    <= lit && !hbErr;
                end
                default:
                begin
                    telOkLed   <= lit;
                    boardOkLed <= lit;
                    ifOkLed    <= lit;
                end
            endcase
        end
    end

    property p_tz;
        @(posedge clock) disable iff (rst)
        (linkTimeoutSetting == '0) |=> !busLossAlarm;
    endproperty
    a_tz: assert property (p_tz)
        else $error("alarm raised with zero timeout");

    property p_boot;
        @(posedge clock) disable iff (rst)
        (!timeoutZero && !techBoardFitted && (prof4 || prof5) &&
         !everExchanged_q) |=> busLossAlarm;
    endproperty
    a_boot: assert property (p_boot)
        else $error("no alarm before first exchange");

    property p_r3;
        @(posedge clock) disable iff (rst)
        (!timeoutZero && !techBoardFitted && prof4 && lossState_q &&
         respMonActive) |=> busLossAlarm && !$rose(busLossFault);
    endproperty
    a_r3: assert property (p_r3)
        else $error("profile 4 bus error without alarm");

    property p_r4;
        @(posedge clock) disable iff (rst)
        (!timeoutZero && !techBoardFitted && prof5 && lossState_q &&
         respMonActive && ctrlWordOn) |=> busLossFault [*2];
    endproperty
    a_r4: assert property (p_r4)
        else $error("profile 5 bus error without fault");

    property p_r5;
        @(posedge clock) disable iff (rst)
        (!timeoutZero && techBoardFitted && lossAny && techFaultCfg)
        |=> busLossFault;
    endproperty
    a_r5: assert property (p_r5)
        else $error("technology board fault not applied");

    property p_cs;
        @(posedge clock) disable iff (rst)
        (state_q == ffls_pkg::ST_CSFAIL) ##1 (state_q ==
         ffls_pkg::ST_CSFAIL) |-> !telOkLed && ifOkLed;
    endproperty
    a_cs: assert property (p_cs)
        else $error("checksum fail led pattern wrong");

    property p_ram;
        @(posedge clock) disable iff (rst)
        (state_q == ffls_pkg::ST_RAMFAIL) |=> telOkLed && ifOkLed;
    endproperty
    a_ram: assert property (p_ram)
        else $error("ram fail led pattern wrong");

    property p_prun;
        @(posedge clock) disable iff (rst)
        (state_q == ffls_pkg::ST_PRUN) |=> boardOkLed && !ifOkLed;
    endproperty
    a_prun: assert property (p_prun)
        else $error("parameterizing led pattern wrong");

    property p_tel;
        @(posedge clock) disable iff (rst)
        !exchanging_q |=> !telOkLed ||
        $past(state_q) != ffls_pkg::ST_ONLINE;
    endproperty
    a_tel: assert property (p_tel)
        else $error("telegram led lit without exchange");

    property p_bad;
        @(posedge clock) disable iff (rst)
        (cfgStrobe && cfgIdCount > ffls_pkg::ID_COUNT_MAX)
        |=> badParam && !configured_q ##2 !linkConnected;
    endproperty
    a_bad: assert property (p_bad)
        else $error("bad configuration accepted");

endmodule // ffls_status

`default_nettype wire

// ---- verification/ffls_master_model.sv ----
// behavioural fieldbus master facing the status block
// assumes the bench calls its tasks; fields change at the falling edge
`timescale 1ns/1ns
`default_nettype none
module ffls_master_model
(
    input  wire logic       clock,
    output logic            cfgStrobe,
    output logic [2:0]      cfgIdCount,
    output logic            cfgProfileValid,
    output logic            netDataActive,
    output logic            busError
);
    initial
    begin
        cfgStrobe = 1'b0;
        cfgIdCount = 3'h7;
        cfgProfileValid = 1'b0;
        netDataActive = 1'b0;
        busError = 1'b0;
    end
    // fields only valid with the strobe, inverted after it
    task automatic sendCfg(input logic [2:0] n, input logic ok);
        @(negedge clock);
        cfgStrobe = 1'b1;
        cfgIdCount = n;
        cfgProfileValid = ok;
        @(negedge clock);
        cfgStrobe = 1'b0;
        cfgIdCount = ~n;
        cfgProfileValid = ~ok;
    endtask
    task automatic exchange(input logic on);
        @(negedge clock);
        netDataActive = on;
    endtask
    // link cut: net data stops with the error
    task automatic breakLink;
        @(negedge clock);
        busError = 1'b1;
        netDataActive = 1'b0;
        @(negedge clock);
        busError = 1'b0;
    endtask
endmodule // ffls_master_model
`default_nettype wire

// ---- verification/ffls_status_test.sv ----
// self-checking bench for the fault and led status block
// assumes the master model file is compiled first; short flash period
`timescale 1ns/1ns
`default_nettype none
module ffls_status_test;
    logic clock = 1'b0, rst = 1'b1, ctrlWordOn = 1'b0, respMonActive = 1'b0;
    logic techBoardFitted = 1'b0, techAlarmCfg = 1'b0, techFaultCfg = 1'b0;
    logic faultAck = 1'b0, selfTestDone = 1'b0, checksumFail = 1'b0;
    logic ramFail = 1'b0, boardCancelParam = 1'b0, paramStart = 1'b0;
    logic paramDone = 1'b0, hbStrobe = 1'b0, syncMode = 1'b0;
    logic hbRun = 1'b0, hbBad = 1'b0;
    logic [7:0] linkTimeoutSetting = 8'h00, hbValue = 8'h00;
    logic [3:0] linkProfileSelect = 4'h4;
    logic cfgStrobe, cfgProfileValid, netDataActive, busError, badParam;
    logic [2:0] cfgIdCount;
    logic busLossAlarm, busLossFault, linkConnected;
    logic telOkLed, boardOkLed, ifOkLed;
    int num_errors = 0, compares = 0, hbTick = 0;
    logic [3:0] tProf [4] = '{4'h4, 4'h5, 4'h5, 4'h5};
    logic [7:0] tTo [4] = '{8'h05, 8'h05, 8'h05, 8'h00};
    logic [1:0] tCwAf [4] = '{2'b01, 2'b00, 2'b10, 2'b10};
    localparam int PCS = 0, PRAM = 1, PDONE = 2, PSTART = 3;
    localparam int PEND = 4, PCANCEL = 5, PACK = 6;
    ffls_master_model master (.clock(clock), .cfgStrobe(cfgStrobe),
        .cfgIdCount(cfgIdCount), .cfgProfileValid(cfgProfileValid),
        .netDataActive(netDataActive), .busError(busError));
    ffls_status #(.FLASH_CYCLES(16), .HB_CYCLES(40), .TO_W(8)) dut (
        .clock(clock), .rst(rst), .linkTimeoutSetting(linkTimeoutSetting),
        .linkProfileSelect(linkProfileSelect), .ctrlWordOn(ctrlWordOn),
        .respMonActive(respMonActive), .techBoardFitted(techBoardFitted),
        .techAlarmCfg(techAlarmCfg), .techFaultCfg(techFaultCfg),
        .faultAck(faultAck), .selfTestDone(selfTestDone),
        .checksumFail(checksumFail), .ramFail(ramFail),
        .boardCancelParam(boardCancelParam), .paramStart(paramStart),
        .paramDone(paramDone), .hbStrobe(hbStrobe), .hbValue(hbValue),
        .syncMode(syncMode), .cfgStrobe(cfgStrobe), .cfgIdCount(cfgIdCount),
        .cfgProfileValid(cfgProfileValid), .netDataActive(netDataActive),
        .busError(busError), .busLossAlarm(busLossAlarm),
        .busLossFault(busLossFault), .badParam(badParam),
        .linkConnected(linkConnected), .telOkLed(telOkLed),
        .boardOkLed(boardOkLed), .ifOkLed(ifOkLed));
    always #5 clock = ~clock;
    // converter heartbeat every 8 cycles, well inside the 40 cycle limit
    always @(negedge clock)
    begin
        hbStrobe <= 1'b0;
        hbTick <= hbTick + 1;
        if (hbRun && hbTick % 8 == 0)
        begin
            hbStrobe <= 1'b1;
            hbValue <= hbValue + (hbBad ? 8'h03 : 8'h01);
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge clock);
    endtask
    // strobe inputs picked by number, each driven here directly
    task automatic setIn(input int sel, input logic v);
        case (sel)
            PCS:     checksumFail = v;
            PRAM:    ramFail = v;
            PDONE:   selfTestDone = v;
            PSTART:  paramStart = v;
            PEND:    paramDone = v;
            PCANCEL: boardCancelParam = v;
            default: faultAck = v;
        endcase
    endtask
    task automatic pulse(input int sel);
        @(negedge clock);
        setIn(sel, 1'b1);
        @(negedge clock);
        setIn(sel, 1'b0);
        wt(3);
    endtask
    // lit cycles over two flash periods: 32 on, 16 flashing, 0 dark
    task automatic leds(input logic [7:0] t, b, i);
        logic [7:0] nt, nb, ni;
        nt = 8'h00;
        nb = 8'h00;
        ni = 8'h00;
        repeat (32)
        begin
            @(negedge clock);
            nt += telOkLed;
            nb += boardOkLed;
            ni += ifOkLed;
        end
        check(nt, t);
        check(nb, b);
        check(ni, i);
    endtask
    task automatic flags(input logic a, f);
        wt(4);
        check(busLossAlarm, a);
        check(busLossFault, f);
    endtask
    task automatic doReset;
        @(negedge clock);
        rst = 1'b1;
        wt(6);
        rst = 1'b0;
    endtask
    task automatic final_report;
        $display("mismatches %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        wt(6);
        rst = 1'b0;
        pulse(PCS);
        leds(8'h00, 8'h10, 8'h20);
        doReset();
        pulse(PRAM);
        leds(8'h20, 8'h10, 8'h20);
        doReset();
        hbRun = 1'b1;
        pulse(PDONE);
        leds(8'h10, 8'h10, 8'h10);
        pulse(PSTART);
        leds(8'h10, 8'h20, 8'h00);
        pulse(PEND);
        leds(8'h00, 8'h10, 8'h10);
        flags(1'b0, 1'b0);
        linkTimeoutSetting = 8'h05;
        flags(1'b1, 1'b0);
        linkProfileSelect = 4'h5;
        flags(1'b1, 1'b0);
        techBoardFitted = 1'b1;
        flags(1'b0, 1'b0);
        techAlarmCfg = 1'b1;
        techFaultCfg = 1'b1;
        flags(1'b1, 1'b1);
        techBoardFitted = 1'b0;
        techAlarmCfg = 1'b0;
        techFaultCfg = 1'b0;
        linkProfileSelect = 4'h4;
        pulse(PACK);
        master.exchange(1'b1);
        for (int n = 0; n < 16; n++)
        begin
            logic cfgOk;
            cfgOk = n[3] && n[2:0] >= 1 && n[2:0] <= 4;
            master.sendCfg(n[2:0], n[3]);
            wt(4);
            check(badParam, !cfgOk);
            check(linkConnected, cfgOk);
            if (n == 0)
                leds(8'h00, 8'h10, 8'h10);
        end
        // last loop telegram is refused, so reconnect first
        master.sendCfg(3'h2, 1'b1);
        wt(4);
        leds(8'h10, 8'h10, 8'h10);
        flags(1'b0, 1'b0);
        syncMode = 1'b1;
        leds(8'h08, 8'h10, 8'h10);
        syncMode = 1'b0;
        respMonActive = 1'b1;
        for (int k = 0; k < 4; k++)
        begin
            logic expF;
            expF = tCwAf[k][1] && tTo[k] != 8'h00;
            linkProfileSelect = tProf[k];
            linkTimeoutSetting = tTo[k];
            ctrlWordOn = tCwAf[k][1];
            master.breakLink();
            flags(tCwAf[k][0], expF);
            if (k == 0)
                leds(8'h00, 8'h10, 8'h10);
            master.sendCfg(3'h2, 1'b1);
            master.exchange(1'b1);
            wt(4);
            check(busLossFault, expF);
            pulse(PACK);
        end
        pulse(PCANCEL);
        leds(8'h10, 8'h10, 8'h10);
        pulse(PSTART);
        pulse(PEND);
        master.exchange(1'b0);
        leds(8'h00, 8'h10, 8'h10);
        hbBad = 1'b1;
        wt(9);
        hbBad = 1'b0;
        wt(4);
        leds(8'h10, 8'h10, 8'h10);
        final_report();
    end
endmodule // ffls_status_test
`default_nettype wire
